/* common/acrr_pkg.sv */
package acrr_pkg;

  localparam int unsigned ACRR_CODE_W = 24;
  localparam logic [23:0] ACRR_POS_FULL_SCALE = 24'h7FFFFF;
  localparam logic [23:0] ACRR_NEG_FULL_SCALE = 24'h800000;
  localparam logic [23:0] ACRR_EXT_POS_REF = 24'h666666;
  localparam logic [23:0] ACRR_EXT_NEG_REF = 24'h99999A;

  localparam logic [1:0] ACRR_RD_OPCODE = 2'h1;
  localparam logic [1:0] ACRR_WR_OPCODE = 2'h2;
  localparam logic [3:0] ACRR_STATUS_ADDR = 4'h2;
  localparam int unsigned ACRR_CHECK_ERR_BIT = 4;
  localparam int unsigned ACRR_NEW_DATA_BIT = 0;

  localparam logic [7:0] ACRR_CRC_POLY = 8'h07;
  localparam logic [7:0] ACRR_CRC_INIT = 8'hFF;
  localparam logic [7:0] ACRR_PAD_BYTE = 8'h00;

  localparam logic [5:0] ACRR_HDR_BITS = 6'h08;
  localparam logic [5:0] ACRR_CRC_BITS = 6'h08;
  localparam logic [5:0] ACRR_DATA16_BITS = 6'h10;
  localparam logic [5:0] ACRR_DATA24_BITS = 6'h18;
  localparam logic [5:0] ACRR_MSB_BYTE_BITS = 6'h08;
  localparam logic [5:0] ACRR_CMD_BITS = 6'h10;
  localparam logic [5:0] ACRR_CMD_CRC_BITS = 6'h18;

  localparam logic [1:0] ACRR_STBY_CYCLES = 2'h3;
  localparam int unsigned ACRR_SYNC_STAGES = 3;
  localparam int unsigned ACRR_PINS = 3;

  typedef enum logic [1:0] {
    ACRR_MODE_SYNC = 2'h0,
    ACRR_MODE_START_STOP = 2'h1,
    ACRR_MODE_ONE_SHOT = 2'h2
  } acrr_mode_e;

  typedef struct packed {
    logic dual_function_output_select;
    logic standby_after_conversion_select;
    logic status_header_en;
    logic check_byte_en;
    logic res16;
    acrr_mode_e mode;
  } acrr_fourth_cfg_s;

  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] data;
  } acrr_reg_cmd_s;

  typedef struct packed {
    logic [7:5] upper;
    logic [3:1] lower;
  } acrr_flags_s;

endpackage : acrr_pkg

/* design/acrr_pair_buffer.sv */
`timescale 1ns/100ps
`default_nettype none
module acrr_pair_buffer (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [acrr_pkg::ACRR_CODE_W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [acrr_pkg::ACRR_CODE_W-1:0] out_data_out
);
  import acrr_pkg::*;

  logic [ACRR_CODE_W-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  assign push = in_valid_in && (count_r != 2'h2);
  assign pop = out_ready_in && (count_r != 2'h0);
  assign in_ready_out = (count_r != 2'h2);
  assign out_valid_out = (count_r != 2'h0);
  assign out_data_out = mem_r[rd_ptr_r];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= 2'(count_r + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule : acrr_pair_buffer
`default_nettype wire

/* design/acrr_readout.sv */
`timescale 1ns/100ps
`default_nettype none
module acrr_readout (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic SDI_IN,
  input wire acrr_pkg::acrr_fourth_cfg_s CONFIG_IN,
  input wire acrr_pkg::acrr_flags_s FLAGS_IN,
  input wire logic CONV_START_IN,
  input wire logic MOD_TICK_IN,
  input wire logic RESULT_VALID_IN,
  input wire logic signed [25:0] RESULT_RAW_IN,
  output logic RESULT_READY_OUT,
  input wire logic [7:0] REG_RD_DATA_IN,
  output logic [3:0] REG_RD_ADDR_OUT,
  output acrr_pkg::acrr_reg_cmd_s REG_CMD_OUT,
  output logic CHECK_ERROR_OUT,
  output logic CONVERSION_READY_N_OUT,
  output logic SHARED_DATA_READY_PIN_OUT
);
  import acrr_pkg::*;

  // pin synchronisers: a level counts once stages two and three agree
  logic [ACRR_PINS-1:0] pin_raw;
  logic [ACRR_PINS-1:0] pin_filt_r;
  logic [ACRR_PINS-1:0] pin_prev_r;

  assign pin_raw = {SDI_IN, CS_N_IN, SCLK_IN};

  genvar gi;
  generate
    for (gi = 0; gi < ACRR_PINS; gi++) begin : g_sync
      logic [ACRR_SYNC_STAGES-1:0] st_r;
      always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
          st_r <= {ACRR_SYNC_STAGES{gi == 1}};
          pin_filt_r[gi] <= (gi == 1);
          pin_prev_r[gi] <= (gi == 1);
        end else begin
          st_r <= {st_r[ACRR_SYNC_STAGES-2:0], pin_raw[gi]};
          if (st_r[1] == st_r[2]) begin
            pin_filt_r[gi] <= st_r[2];
          end
          pin_prev_r[gi] <= pin_filt_r[gi];
        end
      end
    end
  endgenerate

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_n;
  logic sdi;

  assign cs_n = pin_filt_r[1];
  assign sdi = pin_filt_r[2];
  assign cs_fall = pin_prev_r[1] && !cs_n;
  assign cs_rise = !pin_prev_r[1] && cs_n;
  assign sclk_rise = !cs_n && !pin_prev_r[0] && pin_filt_r[0];
  assign sclk_fall = !cs_n && pin_prev_r[0] && !pin_filt_r[0];

  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic b);
    crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? ACRR_CRC_POLY : 8'h00);
  endfunction : crc_step

  function automatic logic [7:0] crc16(input logic [15:0] d);
    logic [7:0] c;
    c = ACRR_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = crc_step(c, d[i]);
    end
    crc16 = c;
  endfunction : crc16

  // saturation of the raw modulator word into the 24-bit code space
  logic [23:0] sat_code;
  always_comb begin
    if (RESULT_RAW_IN > 26'sh07FFFFF) begin
      sat_code = ACRR_POS_FULL_SCALE;
    end else if (RESULT_RAW_IN < -26'sh0800000) begin
      sat_code = ACRR_NEG_FULL_SCALE;
    end else begin
      sat_code = RESULT_RAW_IN[23:0];
    end
  end

  // result buffer in the data path; held off while a read is shifting
  logic buf_valid;
  logic buf_ready;
  logic [23:0] buf_data;
  logic buf_in_ready;
  logic in_frame_r;
  logic shifting_r;
  logic prep_r;

  acrr_pair_buffer u_buf (
    .clk_in(CORE_CLK_IN),
    .reset_in(RESET_IN),
    .in_valid_in(RESULT_VALID_IN),
    .in_ready_out(buf_in_ready),
    .in_data_in(sat_code),
    .out_valid_out(buf_valid),
    .out_ready_in(buf_ready),
    .out_data_out(buf_data)
  );

  // the old result stays while shifting has begun
  assign buf_ready = prep_r && !shifting_r;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      RESULT_READY_OUT <= 1'b0;
    end else begin
      RESULT_READY_OUT <= buf_in_ready;
    end
  end

  // ready pulse ahead of each new result: one cycle, or until a read stops shifting
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      prep_r <= 1'b0;
    end else if (prep_r) begin
      prep_r <= shifting_r;
    end else begin
      prep_r <= buf_valid && MOD_TICK_IN && !shifting_r;
    end
  end

  logic load;
  logic [23:0] result_r;
  assign load = buf_ready && buf_valid;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      result_r <= 24'h000000;
    end else if (load) begin
      result_r <= buf_data;
    end
  end

  // frame bookkeeping
  logic [5:0] idx_r;
  logic [5:0] rx_cnt_r;
  logic [5:0] crc_pos_r;
  logic [5:0] total_r;
  logic [5:0] msb_edge_r;
  logic [39:0] out_sr_r;
  logic [7:0] crc_out_r;
  logic [23:0] in_sr_r;
  logic rd_pending_r;
  logic [7:0] rd_data_r;
  logic done_r;
  logic new_r;
  logic spi_err_r;
  logic ready_n_r;
  logic [1:0] stby_cnt_r;
  logic [7:0] header;
  logic [23:0] field;
  logic msb_done;

  assign header = {FLAGS_IN.upper, spi_err_r, FLAGS_IN.lower, new_r};
  assign msb_done = sclk_fall && shifting_r && !done_r && (idx_r + 6'h01 == msb_edge_r);

  always_comb begin
    if (rd_pending_r) begin
      field = {rd_data_r, ACRR_PAD_BYTE, ACRR_PAD_BYTE};
    end else if (CONFIG_IN.res16) begin
      field = {result_r[23:8], ACRR_PAD_BYTE};
    end else begin
      field = result_r;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      in_frame_r <= 1'b0;
      shifting_r <= 1'b0;
      done_r <= 1'b0;
    end else if (cs_rise) begin
      in_frame_r <= 1'b0;
      shifting_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (cs_fall) begin
        in_frame_r <= 1'b1;
      end
      if (in_frame_r && sclk_rise) begin
        shifting_r <= 1'b1;
      end
      if (sclk_fall && shifting_r && (idx_r + 6'h01 == total_r)) begin
        done_r <= 1'b1;
      end
    end
  end

  // output frame layout is fixed at chip-select fall so mid-frame config
  // changes cannot tear it apart; the command decode reads check_byte_en live at frame end
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      crc_pos_r <= ACRR_DATA24_BITS;
      total_r <= ACRR_DATA24_BITS;
      msb_edge_r <= ACRR_MSB_BYTE_BITS;
    end else if (cs_fall) begin
      crc_pos_r <= (CONFIG_IN.status_header_en ? ACRR_HDR_BITS : 6'h00)
        + (CONFIG_IN.res16 ? ACRR_DATA16_BITS : ACRR_DATA24_BITS);
      total_r <= (CONFIG_IN.status_header_en ? ACRR_HDR_BITS : 6'h00)
        + (CONFIG_IN.res16 ? ACRR_DATA16_BITS : ACRR_DATA24_BITS)
        + (CONFIG_IN.check_byte_en ? ACRR_CRC_BITS : 6'h00);
      msb_edge_r <= CONFIG_IN.status_header_en ? ACRR_HDR_BITS + ACRR_MSB_BYTE_BITS
        : ACRR_MSB_BYTE_BITS;
    end
  end

  // output shifter and running check byte
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      out_sr_r <= 40'h0000000000;
      crc_out_r <= ACRR_CRC_INIT;
      idx_r <= 6'h00;
    end else if (cs_fall) begin
      out_sr_r <= CONFIG_IN.status_header_en ? {header, field, ACRR_PAD_BYTE}
        : {field, ACRR_PAD_BYTE, ACRR_PAD_BYTE};
      crc_out_r <= ACRR_CRC_INIT;
      idx_r <= 6'h00;
    end else if (sclk_fall && shifting_r && !done_r) begin
      idx_r <= 6'(idx_r + 6'h01);
      if (idx_r < crc_pos_r) begin
        crc_out_r <= crc_step(crc_out_r, out_sr_r[39]);
        out_sr_r <= {out_sr_r[38:0], 1'b0};
      end else begin
        crc_out_r <= {crc_out_r[6:0], 1'b0};
      end
    end
  end

  // input shifter
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      in_sr_r <= 24'h000000;
      rx_cnt_r <= 6'h00;
    end else if (cs_fall) begin
      rx_cnt_r <= 6'h00;
    end else if (sclk_rise && in_frame_r) begin
      in_sr_r <= {in_sr_r[22:0], sdi};
      if (rx_cnt_r != 6'h3F) begin
        rx_cnt_r <= 6'(rx_cnt_r + 6'h01);
      end
    end
  end

  // command decode at frame end; only the trailing bytes count
  logic [15:0] cmd;
  logic cmd_ok;
  logic cmd_long;
  logic crc_bad;
  assign cmd = CONFIG_IN.check_byte_en ? in_sr_r[23:8] : in_sr_r[15:0];
  assign cmd_long = rx_cnt_r >= (CONFIG_IN.check_byte_en ? ACRR_CMD_CRC_BITS : ACRR_CMD_BITS);
  assign crc_bad = CONFIG_IN.check_byte_en && (crc16(cmd) != in_sr_r[7:0]);
  assign cmd_ok = cs_rise && in_frame_r && cmd_long;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      REG_CMD_OUT <= '0;
      REG_RD_ADDR_OUT <= 4'h0;
      rd_pending_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      REG_CMD_OUT.wr <= 1'b0;
      // track register data between frames so the chip-select fall load
      // sees the data of the address decoded in the previous frame
      if (!in_frame_r) begin
        rd_data_r <= REG_RD_DATA_IN;
      end
      if (cs_rise && in_frame_r) begin
        rd_pending_r <= 1'b0;
      end
      if (cmd_ok && !crc_bad && cmd[15:14] == ACRR_RD_OPCODE && cmd[13:12] == 2'h0) begin
        rd_pending_r <= 1'b1;
        REG_RD_ADDR_OUT <= cmd[11:8];
      end
      if (cmd_ok && !crc_bad && cmd[15:14] == ACRR_WR_OPCODE && cmd[13:12] == 2'h0
          && (!spi_err_r || cmd[11:8] == ACRR_STATUS_ADDR)) begin
        REG_CMD_OUT.wr <= 1'b1;
        REG_CMD_OUT.addr <= cmd[11:8];
        REG_CMD_OUT.data <= cmd[7:0];
      end
    end
  end

  // check error flag: a new error wins over a clear in the same frame
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      spi_err_r <= 1'b0;
    end else if (cmd_ok && crc_bad) begin
      spi_err_r <= 1'b1;
    end else if (cmd_ok && cmd[15:14] == ACRR_WR_OPCODE && cmd[11:8] == ACRR_STATUS_ADDR
                 && cmd[ACRR_CHECK_ERR_BIT]) begin
      spi_err_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      CHECK_ERROR_OUT <= 1'b0;
    end else begin
      CHECK_ERROR_OUT <= spi_err_r;
    end
  end

  // header new-data bit; a load in the same cycle wins over the clear
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      new_r <= 1'b0;
    end else if (load) begin
      new_r <= 1'b1;
    end else if (msb_done && !rd_pending_r) begin
      new_r <= 1'b0;
    end
  end

  // ready signal (active low)
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      ready_n_r <= 1'b1;
      stby_cnt_r <= 2'h0;
    end else if (load) begin
      ready_n_r <= 1'b0;
      stby_cnt_r <= ACRR_STBY_CYCLES;
    end else begin
      if (stby_cnt_r != 2'h0) begin
        stby_cnt_r <= 2'(stby_cnt_r - 2'h1);
      end
      // high ahead of a load, one cycle or until shifting ends, so an unread result still ends
      // in a fresh falling edge
      if (CONV_START_IN || (prep_r && buf_valid)
          || (!prep_r && buf_valid && MOD_TICK_IN && !shifting_r)) begin
        ready_n_r <= 1'b1;
      end else if (CONFIG_IN.standby_after_conversion_select && stby_cnt_r == 2'h1) begin
        ready_n_r <= 1'b1;
      end else if (msb_done && !rd_pending_r && CONFIG_IN.mode != ACRR_MODE_ONE_SHOT) begin
        ready_n_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      CONVERSION_READY_N_OUT <= 1'b1;
    end else begin
      CONVERSION_READY_N_OUT <= ready_n_r;
    end
  end

  // shared pin: data only between first rising clock and frame end
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      SHARED_DATA_READY_PIN_OUT <= 1'b1;
    end else if (in_frame_r && !cs_rise && (shifting_r || sclk_rise) && !done_r) begin
      SHARED_DATA_READY_PIN_OUT <= (idx_r < crc_pos_r) ? out_sr_r[39] : crc_out_r[7];
    end else if (CONFIG_IN.dual_function_output_select) begin
      SHARED_DATA_READY_PIN_OUT <= ready_n_r;
    end
  end
endmodule : acrr_readout
`default_nettype wire

/* test/acrr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module acrr_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic pin_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // mode 0 frame, msb first; the clock rests low between frames
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    cs_n_out = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out = tx[i];
      #62.5 sclk_out = 1'b1;
      // late in the high phase, after the pin has settled
      #56 rx[i] = pin_in;
      #6.5 sclk_out = 1'b0;
    end
    #62.5 cs_n_out = 1'b1;
    // released line must not keep showing the last bit
    sdi_out = ~sdi_out;
    #300;
  endtask : xfer
endmodule : acrr_host_model
`default_nettype wire

/* test/acrr_readout_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module acrr_readout_properties (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic CS_N_IN,
  input wire acrr_pkg::acrr_fourth_cfg_s CONFIG_IN,
  input wire logic CONV_START_IN,
  input wire logic MOD_TICK_IN,
  input wire acrr_pkg::acrr_reg_cmd_s REG_CMD_OUT,
  input wire logic CHECK_ERROR_OUT,
  input wire logic CONVERSION_READY_N_OUT,
  input wire logic SHARED_DATA_READY_PIN_OUT
);
  import acrr_pkg::*;
  logic [3:0] cs_hi_r;
  logic rdy_n;
  logic pin;
  logic dual;
  logic stby;
  assign rdy_n = CONVERSION_READY_N_OUT;
  assign pin = SHARED_DATA_READY_PIN_OUT;
  assign dual = CONFIG_IN.dual_function_output_select;
  assign stby = CONFIG_IN.standby_after_conversion_select;
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  // saturates at 15: long enough for the frame end to be decoded
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN || !CS_N_IN) begin
      cs_hi_r <= 4'h0;
    end else if (cs_hi_r != 4'hF) begin
      cs_hi_r <= cs_hi_r + 4'h1;
    end
  end
  a_reset_quiet: assert property (
    $fell(RESET_IN) |-> rdy_n && pin && !CHECK_ERROR_OUT && !REG_CMD_OUT.wr)
    else $error("outputs not idle after reset");
  a_start_high: assert property (
    CONV_START_IN |-> ##[1:3] rdy_n)
    else $error("ready not raised by start");
  a_stby_pulse: assert property (
    stby && $fell(rdy_n) |-> !rdy_n [*2] ##[1:2] rdy_n)
    else $error("standby ready pulse wrong length");
  a_wr_blocked: assert property (
    CHECK_ERROR_OUT && REG_CMD_OUT.wr |-> REG_CMD_OUT.addr == ACRR_STATUS_ADDR)
    else $error("write passed while check error set");
  a_wr_single: assert property (
    REG_CMD_OUT.wr |=> !REG_CMD_OUT.wr)
    else $error("write strobe longer than one cycle");
  a_err_hold: assert property (
    CHECK_ERROR_OUT && cs_hi_r == 4'hF |=> CHECK_ERROR_OUT)
    else $error("check error cleared without a frame");
  a_idle_hold: assert property (
    !dual && !$past(dual) && cs_hi_r == 4'hF |-> $stable(pin))
    else $error("idle pin moved with dual select off");
  a_idle_mirror: assert property (
    dual && $past(dual) && cs_hi_r == 4'hF |-> pin == rdy_n || pin == $past(rdy_n))
    else $error("idle pin not mirroring ready");
  a_cs_return: assert property (
    dual && $rose(CS_N_IN) |-> ##[4:8] (pin == rdy_n || pin == $past(rdy_n)))
    else $error("pin not back to ready after frame");
  a_oneshot_low: assert property (
    CONFIG_IN.mode == ACRR_MODE_ONE_SHOT && !stby && !rdy_n && !CONV_START_IN
    && !$past(CONV_START_IN) && !MOD_TICK_IN && !$past(MOD_TICK_IN) |=> !rdy_n)
    else $error("one-shot ready rose without start");
  c_err: cover property (CHECK_ERROR_OUT);
  c_stby: cover property (stby && $fell(rdy_n));
  c_wr: cover property (REG_CMD_OUT.wr);
endmodule : acrr_readout_properties
bind acrr_readout acrr_readout_properties u_props (
  .CORE_CLK_IN, .RESET_IN, .CS_N_IN, .CONFIG_IN, .CONV_START_IN, .MOD_TICK_IN,
  .REG_CMD_OUT, .CHECK_ERROR_OUT, .CONVERSION_READY_N_OUT, .SHARED_DATA_READY_PIN_OUT
);
`default_nettype wire

/* test/acrr_readout_test.sv */
`timescale 1ns/100ps
`default_nettype none
module acrr_readout_test;
  import acrr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, sdi, rrdy, err, rdy_n, pin;
  logic start = 1'b0;
  logic tick = 1'b0;
  logic rvalid = 1'b0;
  logic signed [25:0] raw = '0;
  acrr_fourth_cfg_s cfg = '0;
  acrr_flags_s flags = '{3'b101, 3'b010};
  logic [3:0] rd_addr;
  logic [7:0] reg_data;
  // register file stand-in: the data tracks the address asked for
  assign reg_data = {rd_addr, ~rd_addr};
  acrr_reg_cmd_s cmd, last_cmd;
  logic [39:0] rx;
  int error_cnt = 0;
  int comparisons = 0;
  int wr_cnt = 0;
  always #4 clk = ~clk;
  acrr_readout u_dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .SCLK_IN(sclk), .CS_N_IN(cs_n),
    .SDI_IN(sdi), .CONFIG_IN(cfg), .FLAGS_IN(flags), .CONV_START_IN(start),
    .MOD_TICK_IN(tick), .RESULT_VALID_IN(rvalid), .RESULT_RAW_IN(raw),
    .RESULT_READY_OUT(rrdy), .REG_RD_DATA_IN(reg_data), .REG_RD_ADDR_OUT(rd_addr),
    .REG_CMD_OUT(cmd), .CHECK_ERROR_OUT(err), .CONVERSION_READY_N_OUT(rdy_n),
    .SHARED_DATA_READY_PIN_OUT(pin));
  acrr_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .pin_in(pin));
  always @(posedge clk) begin
    if (cmd.wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      last_cmd <= cmd;
    end
  end
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] crc8(input logic [31:0] d, input int n);
    logic [7:0] c;
    c = ACRR_CRC_INIT;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? ACRR_CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic frame(input logic [39:0] tx, input int n);
    u_host.xfer(tx, n, rx);
    cyc(1);
  endtask : frame
  task automatic push(input logic signed [25:0] v);
    logic ok;
    raw = v;
    rvalid = 1'b1;
    for (int i = 0; i < 20; i++) begin
      ok = rrdy;
      cyc(1);
      if (ok === 1'b1) break;
    end
    rvalid = 1'b0;
  endtask : push
  task automatic tick_once;
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    for (int i = 0; i < 10 && rdy_n !== 1'b1; i++) cyc(1);
    chk("ready_n pulse", 1'b1, rdy_n);
    for (int i = 0; i < 10 && rdy_n !== 1'b0; i++) cyc(1);
    chk("ready_n low", 1'b0, rdy_n);
  endtask : tick_once
  task automatic load(input logic signed [25:0] v);
    push(v);
    tick_once;
  endtask : load
  task automatic t_short;
    cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ACRR_MODE_SYNC};
    load(26'sh0123456);
    cyc(2);
    chk("pin idle", 1'b0, pin);
    for (int k = 0; k < 2; k++) begin
      frame(40'h0, 24);
      chk("data", 24'h123456, rx[23:0]);
      chk("ready_n read", 1'b1, rdy_n);
      chk("pin after", 1'b1, pin);
    end
    frame(40'h0, 16);
    chk("pin abort", 1'b1, pin);
    frame(40'h004500, 24);
    chk("rd addr", 4'h5, rd_addr);
    frame(40'h0, 24);
    chk("reg data", 24'h5A0000, rx[23:0]);
  endtask : t_short
  task automatic t_sat;
    logic signed [25:0] v [2] = '{26'sh0FFFFFF, 26'sh3000000};
    logic [23:0] e [2] = '{ACRR_POS_FULL_SCALE, ACRR_NEG_FULL_SCALE};
    for (int k = 0; k < 2; k++) begin
      load(v[k]);
      frame(40'h0, 24);
      chk("clamp", e[k], rx[23:0]);
    end
  endtask : t_sat
  task automatic t_long;
    cfg = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, ACRR_MODE_START_STOP};
    load(26'sh0654321);
    frame(40'h0, 16);
    chk("header new", 8'hA5, rx[15:8]);
    chk("ready_n abort", 1'b1, rdy_n);
    frame({16'h0, 16'h0, 8'hD7}, 40);
    chk("header old", 8'hA4, rx[39:32]);
    chk("data", 24'h654321, rx[31:8]);
    chk("crc out", crc8({8'hA4, 24'h654321}, 32), rx[7:0]);
    chk("no error", 1'b0, err);
  endtask : t_long
  task automatic t_res16;
    cfg = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, ACRR_MODE_SYNC};
    load(26'sh0123456);
    frame(40'h0, 16);
    chk("data16", 16'h1234, rx[15:0]);
  endtask : t_res16
  task automatic t_err;
    int n;
    cfg = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, ACRR_MODE_SYNC};
    frame({8'h83, 8'h55, crc8(16'h8355, 16) ^ 8'h01}, 24);
    chk("error set", 1'b1, err);
    n = wr_cnt;
    frame({8'h83, 8'h55, crc8(16'h8355, 16)}, 24);
    chk("blocked", n, wr_cnt);
    frame({8'h82, 8'h10, crc8(16'h8210, 16)}, 24);
    chk("status wr", n + 1, wr_cnt);
    chk("status cmd", {ACRR_STATUS_ADDR, 8'h10}, {last_cmd.addr, last_cmd.data});
    chk("error clr", 1'b0, err);
  endtask : t_err
  task automatic t_modes;
    cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ACRR_MODE_ONE_SHOT};
    load(26'sh0000010);
    frame(40'h0, 24);
    chk("one-shot low", 1'b0, rdy_n);
    load(26'sh0000030);
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(3);
    chk("start high", 1'b1, rdy_n);
    cfg.standby_after_conversion_select = 1'b1;
    load(26'sh0000020);
    cyc(6);
    chk("standby high", 1'b1, rdy_n);
  endtask : t_modes
  task automatic t_buffer;
    cfg = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ACRR_MODE_SYNC};
    push(26'sh0000111);
    push(26'sh0000222);
    cyc(2);
    chk("buffer full", 1'b0, rrdy);
    for (int k = 1; k < 3; k++) begin
      tick_once;
      frame(40'h0, 24);
      chk("buffered", k * 24'h111, rx[23:0]);
    end
  endtask : t_buffer
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #400000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    cyc(20);
    rst = 1'b0;
    cyc(6);
    chk("ready_n rst", 1'b1, rdy_n);
    chk("pin rst", 1'b1, pin);
    t_short;
    t_sat;
    t_long;
    t_res16;
    t_err;
    t_modes;
    t_buffer;
    report_and_stop;
  end
endmodule : acrr_readout_test
`default_nettype wire
